// >>> mdio_mmd_indirect_access.sv
/*
 * Management serial port slave with direct and indirect register access.
 * Assumes MDC, MDIO and the address straps arrive asynchronously, that
 * the extended register space presents ext_rdata in the cycle after an
 * ext_req.rd pulse, and that a pull-up holds MDIO high whenever released.
 */
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Latch 4-bit address from straps at reset.
// - MDC up to 25 MHz, may stop.
// - Bits sampled on rising MDC edge.
// - Frame starts with 0 then 1.
// - Register field indexes 32 16-bit registers.
// - Respond to indices 0x0 through 0x1F.
// - Read: release first turnaround, drive 0.
// - Control bits 4:0 select extended space.
// - Only devices 11111 and 00001 supported.
// - Ignore data register access with bad device.
// - Function 00 reaches the address pointer.
// - Function 01 accesses data, pointer held.
// - Function 10 increments after every access.
// - Function 11 increments after writes only.
module mdio_mmd_indirect_access (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic mdc,
    input wire logic mdio_i,
    output logic mdio_o,
    output logic mdio_oe,
    input wire logic [3:0] phy_addr_strap,
    output logic [3:0] mgmt_addr,
    output mdio_mmd_pkg::ext_req_s ext_req,
    input wire logic [15:0] ext_rdata
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    // All state of the port in one record.
    typedef struct packed {
        logic mdc_s1, mdc_s2, mdc_s3; // MDC synchroniser and edge history.
        logic mdio_s1, mdio_s2; // MDIO synchroniser.
        logic [3:0] strap_s1, strap_s2; // Strap synchroniser.
        logic [1:0] wait_cnt; // Delay before strap latch.
        logic lat; // Address has been latched.
        logic [3:0] phy; // Latched management address.
        mdio_mmd_pkg::frame_st_e st; // Frame position.
        logic [4:0] cnt; // Bits left in field.
        logic [15:0] sh; // Received bits.
        logic [1:0] op; // Frame opcode.
        logic match; // Frame addresses this port.
        logic [4:0] reg_a; // Register index of frame.
        logic [15:0] tx; // Read data shifter.
        logic fetch; // Capture extended read data.
        logic o, oe; // MDIO drive.
        logic [15:0] ctl; // Access-control register.
        logic [15:0] ptr; // Extended address pointer.
        logic [31:0][15:0] regs; // Direct register file.
        mdio_mmd_pkg::ext_req_s req; // Extended request.
    } state_s;

    state_s q, d; // Registered state and its next value.
    logic rise; // Rising MDC edge seen this cycle.
    logic [15:0] nsh; // Shift value including this bit.
    logic [1:0] ctl_fn; // Access function field of the control register.

    // Device address check used for both reads and writes.
    function automatic logic dev_ok(input logic [15:0] c);
        dev_ok = (c[4:0] == mdio_mmd_pkg::DEV_VEND) ||
            (c[4:0] == mdio_mmd_pkg::DEV_PMA);
    endfunction

    assign rise = q.mdc_s2 & ~q.mdc_s3;
    assign nsh = {q.sh[14:0], q.mdio_s2};
    // Function code decides how the address/data register behaves.
    assign ctl_fn = q.ctl[mdio_mmd_pkg::FN_HI:mdio_mmd_pkg::FN_LO];

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Samples pins, runs the frame machine and the register effects.
    always_comb begin
        d = q;
        d.mdc_s1 = mdc;
        d.mdc_s2 = q.mdc_s1;
        d.mdc_s3 = q.mdc_s2;
        d.mdio_s1 = mdio_i;
        d.mdio_s2 = q.mdio_s1;
        d.strap_s1 = phy_addr_strap;
        d.strap_s2 = q.strap_s1;
        d.req.rd = 1'b0;
        d.req.wr = 1'b0;
        // Strap latch once, after the synchroniser has settled.
        if (!q.lat) begin
            d.wait_cnt = q.wait_cnt + 2'h1;
            if (q.wait_cnt == mdio_mmd_pkg::STRAP_WAIT) begin
                d.lat = 1'b1;
                d.phy = q.strap_s2;
            end
        end
        // Extended read data stands in the cycle after the request pulse, so
        // it is taken one edge after ext_req.rd has been seen high.
        if (q.fetch) begin
            d.tx = ext_rdata;
        end
        d.fetch = q.req.rd;
        // Frame machine advances only on MDC edges, so MDC may stop.
        if (rise) begin
            d.sh = nsh;
            d.cnt = q.cnt - 5'h01;
            case (q.st)
                mdio_mmd_pkg::ST_IDLE: begin
                    // First low bit after idle opens a frame.
                    if (!q.mdio_s2) begin
                        d.st = mdio_mmd_pkg::ST_START;
                    end
                end
                mdio_mmd_pkg::ST_START: begin
                    // Second start bit must be high.
                    d.cnt = mdio_mmd_pkg::CNT_OP;
                    d.st = q.mdio_s2 ? mdio_mmd_pkg::ST_OP : mdio_mmd_pkg::ST_IDLE;
                end
                mdio_mmd_pkg::ST_OP: begin
                    if (q.cnt == 5'h00) begin
                        d.op = nsh[1:0];
                        d.cnt = mdio_mmd_pkg::CNT_ADDR;
                        d.st = mdio_mmd_pkg::ST_ADDR;
                    end
                end
                mdio_mmd_pkg::ST_ADDR: begin
                    if (q.cnt == 5'h00) begin
                        // Decode the PHY and register fields.
                        d.reg_a = nsh[4:0];
                        d.match = (nsh[9:5] == {1'b0, q.phy}) &&
                            (q.op == mdio_mmd_pkg::OP_RD ||
                            q.op == mdio_mmd_pkg::OP_WR);
                        d.tx = 16'h0000;
                        if (d.match && q.op == mdio_mmd_pkg::OP_RD) begin
                            // Prepare the read word.
                            if (nsh[4:0] == mdio_mmd_pkg::REG_CTL) begin
                                d.tx = q.ctl;
                            end else if (nsh[4:0] != mdio_mmd_pkg::REG_AD) begin
                                d.tx = q.regs[nsh[4:0]];
                            end else if (!dev_ok(q.ctl)) begin
                                d.tx = 16'h0000;
                            end else if (ctl_fn == mdio_mmd_pkg::FN_ADDR) begin
                                d.tx = q.ptr;
                            end else begin
                                d.req.rd = 1'b1;
                                d.req.dev = q.ctl[4:0];
                                d.req.addr = q.ptr;
                                // The answer is loaded by the fetch stage above.
                            end
                        end
                        d.cnt = mdio_mmd_pkg::CNT_TA;
                        d.st = mdio_mmd_pkg::ST_TA;
                    end
                end
                mdio_mmd_pkg::ST_TA: begin
                    if (q.match && q.op == mdio_mmd_pkg::OP_RD) begin
                        // First turnaround bit was left alone; drive 0 next.
                        d.oe = 1'b1;
                        d.o = 1'b0;
                        if (q.cnt == 5'h00) begin
                            d.o = q.tx[15];
                            d.tx = {q.tx[14:0], 1'b0};
                        end
                    end
                    if (q.cnt == 5'h00) begin
                        d.cnt = mdio_mmd_pkg::CNT_DATA;
                        d.st = mdio_mmd_pkg::ST_DATA;
                    end
                end
                mdio_mmd_pkg::ST_DATA: begin
                    d.o = q.tx[15];
                    d.tx = {q.tx[14:0], 1'b0};
                    if (q.cnt == 5'h00) begin
                        // Frame complete: release the line and act.
                        d.oe = 1'b0;
                        d.o = 1'b0;
                        d.st = mdio_mmd_pkg::ST_IDLE;
                        if (q.match && q.reg_a == mdio_mmd_pkg::REG_AD && dev_ok(q.ctl)) begin
                            if (q.op == mdio_mmd_pkg::OP_WR) begin
                                if (ctl_fn == mdio_mmd_pkg::FN_ADDR) begin
                                    d.ptr = nsh;
                                end else begin
                                    d.req.wr = 1'b1;
                                    d.req.dev = q.ctl[4:0];
                                    d.req.addr = q.ptr;
                                    d.req.wdata = nsh;
                                    if (ctl_fn[1]) begin
                                        d.ptr = q.ptr + 16'h0001;
                                    end
                                end
                            end else if (ctl_fn == mdio_mmd_pkg::FN_INC_RW) begin
                                d.ptr = q.ptr + 16'h0001;
                            end
                        end else if (q.match && q.op == mdio_mmd_pkg::OP_WR) begin
                            if (q.reg_a == mdio_mmd_pkg::REG_CTL) begin
                                d.ctl = nsh;
                            end else if (q.reg_a != mdio_mmd_pkg::REG_AD) begin
                                d.regs[q.reg_a] = nsh;
                            end
                        end
                    end
                end
                default: begin
                    d.st = mdio_mmd_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Whole state record with asynchronous reset to constants.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            q <= '0;
            q.mdc_s1 <= 1'b1;
            q.mdc_s2 <= 1'b1;
            q.mdc_s3 <= 1'b1;
            q.mdio_s1 <= 1'b1;
            q.mdio_s2 <= 1'b1;
            q.ctl <= mdio_mmd_pkg::CTL_RST;
            q.ptr <= mdio_mmd_pkg::PTR_RST;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state record.
    assign mdio_o = q.o;
    assign mdio_oe = q.oe;
    assign mgmt_addr = q.phy;
    assign ext_req = q.req;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // Last data bit of a frame sampled.
    sequence s_done;
        rise && q.st == mdio_mmd_pkg::ST_DATA && q.cnt == 5'h00;
    endsequence
    // Extended-space write completing with an incrementing function.
    sequence s_inc_wr;
        s_done ##0 q.match && q.op == mdio_mmd_pkg::OP_WR &&
            q.reg_a == mdio_mmd_pkg::REG_AD && dev_ok(q.ctl) && ctl_fn[1];
    endsequence
    // Completed access of the address/data register with a supported device.
    sequence s_ad_ok;
        s_done ##0 q.match && q.reg_a == mdio_mmd_pkg::REG_AD && dev_ok(q.ctl);
    endsequence

    a_state_on_edge: assert property (!rise |=> $stable(q.st))
        else $error("frame state moved without an MDC edge");
    a_start_low: assert property (rise && q.st == mdio_mmd_pkg::ST_IDLE && !q.mdio_s2
        |=> q.st == mdio_mmd_pkg::ST_START)
        else $error("start bit not recognised");
    a_drive_read_only: assert property (q.oe |-> q.match && q.op == mdio_mmd_pkg::OP_RD)
        else $error("MDIO driven outside a matched read");
    a_ta_zero: assert property ($rose(q.oe) |-> !q.o && q.st == mdio_mmd_pkg::ST_TA)
        else $error("second turnaround bit not driven low");
    a_release_end: assert property (s_done |=> !q.oe && q.st == mdio_mmd_pkg::ST_IDLE)
        else $error("MDIO not released after data");
    a_ptr_inc: assert property (s_inc_wr |=> q.ptr == $past(q.ptr) + 16'h0001)
        else $error("pointer did not increment after write");
    a_ptr_hold: assert property (ctl_fn == mdio_mmd_pkg::FN_DATA
        |=> $stable(q.ptr))
        else $error("pointer changed under function 01");
    a_bad_dev: assert property (s_done ##0 q.reg_a == mdio_mmd_pkg::REG_AD &&
        !dev_ok(q.ctl) |=> $stable(q.ptr) && !q.req.wr)
        else $error("access with unsupported device acted");
    a_addr_fixed: assert property (q.lat |=> $stable(q.phy) && q.lat)
        else $error("management address changed after latch");
    // Pointer behaviour for functions 00, 10 and 11 at the end of a frame.
    a_ptr_load: assert property (s_ad_ok ##0 q.op == mdio_mmd_pkg::OP_WR &&
        ctl_fn == mdio_mmd_pkg::FN_ADDR |=> q.ptr == $past(nsh))
        else $error("pointer not loaded by address write");
    a_ptr_rd_inc: assert property (s_ad_ok ##0 q.op == mdio_mmd_pkg::OP_RD &&
        ctl_fn == mdio_mmd_pkg::FN_INC_RW |=> q.ptr == $past(q.ptr) + 16'h0001)
        else $error("pointer did not increment after read");
    a_ptr_rd_hold: assert property (s_ad_ok ##0 q.op == mdio_mmd_pkg::OP_RD &&
        ctl_fn == mdio_mmd_pkg::FN_INC_W |=> $stable(q.ptr))
        else $error("pointer moved after read under function 11");
    // Extended requests are single-cycle pulses; reads arm the fetch stage.
    a_rd_pulse: assert property (q.req.rd |=> !q.req.rd && q.fetch)
        else $error("extended read request not a single pulse");
    a_wr_pulse: assert property (q.req.wr |=> !q.req.wr)
        else $error("extended write request not a single pulse");
endmodule
`default_nettype wire

// >>> mdio_mmd_pkg.sv
/*
 * Constants and carrier types for the management serial port.
 * Assumes a 100 MHz system clock and a station clocking MDC at most 25 MHz.
 */
`default_nettype none
package mdio_mmd_pkg;
    // ------------------------------------------------------------
    // Register indices and field values
    // ------------------------------------------------------------
    localparam logic [4:0] REG_CTL = 5'h0D; // Access-control register.
    localparam logic [4:0] REG_AD = 5'h0E; // Address/data register.
    localparam logic [4:0] DEV_VEND = 5'h1F; // Vendor general space.
    localparam logic [4:0] DEV_PMA = 5'h01; // PMA space.
    localparam int FN_HI = 15; // Function field top bit.
    localparam int FN_LO = 14; // Function field low bit.
    localparam logic [1:0] FN_ADDR = 2'h0; // Pointer access.
    localparam logic [1:0] FN_DATA = 2'h1; // Data, no increment.
    localparam logic [1:0] FN_INC_RW = 2'h2; // Data, increment always.
    localparam logic [1:0] FN_INC_W = 2'h3; // Data, increment on writes.
    localparam logic [1:0] OP_RD = 2'h2; // Read opcode.
    localparam logic [1:0] OP_WR = 2'h1; // Write opcode.
    localparam logic [15:0] CTL_RST = 16'h0000; // Control reset value.
    localparam logic [15:0] PTR_RST = 16'h0000; // Pointer reset value.
    // ------------------------------------------------------------
    // Frame field lengths, as last counter values
    // ------------------------------------------------------------
    localparam logic [4:0] CNT_OP = 5'h01; // Two opcode bits.
    localparam logic [4:0] CNT_ADDR = 5'h09; // Ten address bits.
    localparam logic [4:0] CNT_TA = 5'h01; // Two turnaround bits.
    localparam logic [4:0] CNT_DATA = 5'h0F; // Sixteen data bits.
    localparam logic [1:0] STRAP_WAIT = 2'h3; // Cycles before strap latch.
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_START = 3'b001,
        ST_OP = 3'b010,
        ST_ADDR = 3'b011,
        ST_TA = 3'b100,
        ST_DATA = 3'b101
    } frame_st_e;
    // Request to the extended register space.
    typedef struct packed {
        logic rd;
        logic wr;
        logic [4:0] dev;
        logic [15:0] addr;
        logic [15:0] wdata;
    } ext_req_s;
endpackage
`default_nettype wire

// >>> mdio_station.sv
/*
 * Station model that clocks MDC and drives or releases MDIO, one 80 ns bit at a time.
 * Assumes the bench feeds line to the device input and hands over the device drive pins.
 */
`timescale 1ns/100ps
`default_nettype none
module mdio_station (
    input wire logic clk_sys,
    output logic mdc,
    output logic line,
    input wire logic mdio_o,
    input wire logic mdio_oe
);
    logic drv_en; // Station drives the line.
    logic drv_val; // Station drive value.
    initial begin
        mdc = 1'b0;
        drv_en = 1'b0;
        drv_val = 1'b1;
    end
    // The pullup sets the level whenever nobody drives.
    assign line = drv_en ? drv_val : (mdio_oe ? mdio_o : 1'b1);
    // One bit: 40 ns low, then a rise at which the line is sampled.
    task automatic bit_cyc(input logic en, input logic val, output logic seen);
        @(posedge clk_sys);
        mdc <= 1'b0;
        drv_en <= en;
        drv_val <= val;
        repeat (4) @(posedge clk_sys);
        seen = line;
        mdc <= 1'b1;
        repeat (3) @(posedge clk_sys);
    endtask
    // A whole frame; the clock stops low once it is over.
    task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
                         input logic [15:0] wd, output logic [15:0] rd, output logic [1:0] ta);
        logic [13:0] hdr;
        logic s;
        int i;
        hdr = {2'b01, op, phy, rg};
        ta = 2'b00;
        bit_cyc(1'b0, 1'b1, s);
        for (i = 13; i >= 0; i--) begin
            bit_cyc(1'b1, hdr[i], s);
        end
        if (op == mdio_mmd_pkg::OP_WR) begin
            bit_cyc(1'b1, 1'b1, s);
            bit_cyc(1'b1, 1'b0, s);
        end else begin
            bit_cyc(1'b0, 1'b1, ta[1]);
            bit_cyc(1'b0, 1'b1, ta[0]);
        end
        for (i = 15; i >= 0; i--) begin
            bit_cyc(op == mdio_mmd_pkg::OP_WR, wd[i], rd[i]);
        end
        bit_cyc(1'b0, 1'b1, s);
        @(posedge clk_sys);
        mdc <= 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> tb_top.sv
/*
 * Self-checking bench: station frames over MDIO plus a small extended-space model.
 * Assumes the station model drives mdc and the MDIO level, 80 ns per bit.
 */
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin errors++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_top;
    logic clk_sys; // System clock.
    logic rst; // Reset.
    logic mdc; // Management clock.
    logic line; // MDIO level.
    logic mdio_o; // Device drive value.
    logic mdio_oe; // Device drive enable.
    logic [3:0] strap; // Address straps.
    logic [3:0] mgmt_addr; // Latched address.
    mdio_mmd_pkg::ext_req_s ext_req; // Extended request.
    mdio_mmd_pkg::ext_req_s last_wr; // Last extended write.
    mdio_mmd_pkg::ext_req_s last_rd; // Last extended read.
    logic [15:0] ext_rdata; // Extended read data.
    int wr_cnt = 0; // Extended write pulses.
    int errors = 0;
    int checks_done = 0;
    int cyc = 0;
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    mdio_station i_sta (.clk_sys(clk_sys), .mdc(mdc), .line(line), .mdio_o(mdio_o),
                        .mdio_oe(mdio_oe));
    mdio_mmd_indirect_access i_dut (.clk_sys(clk_sys), .rst(rst), .mdc(mdc), .mdio_i(line),
        .mdio_o(mdio_o), .mdio_oe(mdio_oe), .phy_addr_strap(strap), .mgmt_addr(mgmt_addr),
        .ext_req(ext_req), .ext_rdata(ext_rdata));
    // Extended space answers address xor a pattern, one cycle after the request.
    always @(posedge clk_sys) begin
        ext_rdata <= ext_req.addr ^ 16'h5A5A;
        if (ext_req.wr === 1'b1) begin
            wr_cnt <= wr_cnt + 1;
            last_wr <= ext_req;
        end
        if (ext_req.rd === 1'b1) begin
            last_rd <= ext_req;
        end
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            errors++;
            summarize();
        end
    end
    task automatic summarize();
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Shared frame helpers
    // ----------------------------------------
    task automatic wr(input logic [4:0] rg, input logic [15:0] d);
        logic [15:0] r;
        logic [1:0] t;
        i_sta.frame(mdio_mmd_pkg::OP_WR, {1'b0, strap}, rg, d, r, t);
        `CHK("oe_wr", 1'b0, mdio_oe)
    endtask
    task automatic rd(input logic [4:0] rg, input logic [4:0] phy, output logic [15:0] d);
        logic [1:0] t;
        i_sta.frame(mdio_mmd_pkg::OP_RD, phy, rg, 16'h0000, d, t);
        if (phy == {1'b0, strap}) `CHK("turnaround", 2'b10, t)
        `CHK("oe_release", 1'b0, mdio_oe)
    endtask
    task automatic xrd(input logic [15:0] a, input logic [4:0] dv);
        logic [15:0] d;
        rd(mdio_mmd_pkg::REG_AD, {1'b0, strap}, d);
        `CHK("ext_rdata", a ^ 16'h5A5A, d)
        `CHK("rd_addr", a, last_rd.addr)
        `CHK("rd_dev", dv, last_rd.dev)
    endtask
    task automatic xwr(input logic [15:0] a, input logic [4:0] dv, input logic [15:0] v);
        int n;
        n = wr_cnt;
        wr(mdio_mmd_pkg::REG_AD, v);
        `CHK("wr_cnt", n + 1, wr_cnt)
        `CHK("wr_addr_dev_data", {dv, a, v}, {last_wr.dev, last_wr.addr, last_wr.wdata})
    endtask
    task automatic ptr(input logic [4:0] dv, input logic [15:0] e);
        logic [15:0] d;
        wr(mdio_mmd_pkg::REG_CTL, {11'h000, dv});
        rd(mdio_mmd_pkg::REG_AD, {1'b0, strap}, d);
        `CHK("pointer", e, d)
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_direct();
        logic [4:0] regs [3] = '{5'h00, 5'h05, 5'h1F};
        logic [15:0] d;
        logic [1:0] t;
        `CHK("mgmt_addr", 4'hA, mgmt_addr)
        foreach (regs[i]) wr(regs[i], 16'hC3A0 ^ {11'h000, regs[i]});
        foreach (regs[i]) begin
            rd(regs[i], {1'b0, strap}, d);
            `CHK("direct", 16'hC3A0 ^ {11'h000, regs[i]}, d)
        end
        rd(5'h05, 5'h05, d);
        `CHK("other_phy_read", 16'hFFFF, d)
        i_sta.frame(2'h3, {1'b0, strap}, 5'h05, 16'h0000, d, t);
        `CHK("bad_op_data", 16'hFFFF, d)
        `CHK("bad_op_oe", 1'b0, mdio_oe)
    endtask
    task automatic t_fixed();
        ptr(mdio_mmd_pkg::DEV_VEND, 16'h0000);
        wr(mdio_mmd_pkg::REG_AD, 16'h0123);
        ptr(mdio_mmd_pkg::DEV_VEND, 16'h0123);
        wr(mdio_mmd_pkg::REG_CTL, 16'h401F);
        xrd(16'h0123, mdio_mmd_pkg::DEV_VEND);
        xrd(16'h0123, mdio_mmd_pkg::DEV_VEND);
        xwr(16'h0123, mdio_mmd_pkg::DEV_VEND, 16'hBEEF);
        ptr(mdio_mmd_pkg::DEV_VEND, 16'h0123);
    endtask
    task automatic t_incr();
        int n;
        logic [15:0] d;
        wr(mdio_mmd_pkg::REG_CTL, 16'h0001);
        wr(mdio_mmd_pkg::REG_AD, 16'h0040);
        wr(mdio_mmd_pkg::REG_CTL, 16'h8001);
        xrd(16'h0040, mdio_mmd_pkg::DEV_PMA);
        xrd(16'h0041, mdio_mmd_pkg::DEV_PMA);
        xwr(16'h0042, mdio_mmd_pkg::DEV_PMA, 16'h1234);
        ptr(mdio_mmd_pkg::DEV_PMA, 16'h0043);
        wr(mdio_mmd_pkg::REG_CTL, 16'hC001);
        xrd(16'h0043, mdio_mmd_pkg::DEV_PMA);
        xrd(16'h0043, mdio_mmd_pkg::DEV_PMA);
        xwr(16'h0043, mdio_mmd_pkg::DEV_PMA, 16'h00FF);
        xwr(16'h0044, mdio_mmd_pkg::DEV_PMA, 16'hFF00);
        ptr(mdio_mmd_pkg::DEV_PMA, 16'h0045);
        wr(mdio_mmd_pkg::REG_CTL, 16'h8005);
        n = wr_cnt;
        rd(mdio_mmd_pkg::REG_AD, {1'b0, strap}, d);
        `CHK("bad_dev_data", 16'h0000, d)
        `CHK("bad_dev_rd_addr", 16'h0043, last_rd.addr)
        `CHK("bad_dev_rd_dev", mdio_mmd_pkg::DEV_PMA, last_rd.dev)
        wr(mdio_mmd_pkg::REG_AD, 16'h7777);
        `CHK("ignored_wr", n, wr_cnt)
        ptr(mdio_mmd_pkg::DEV_PMA, 16'h0045);
    endtask
    initial begin
        rst = 1'b1;
        strap = 4'hA;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (20) @(posedge clk_sys);
        t_direct();
        t_fixed();
        t_incr();
        summarize();
    end
endmodule
`default_nettype wire
